// File: rtl/fpau_core.sv
// Floating round-normalize exit, unpack, pack and add/subtract datapath
// Contract
// - Round-normalize of infinite/indefinite: copy source, zero count, raise exit.
// - Any floating sum/difference with special operand raises matching exit.
// - Unpack result: low 48 bits kept, top 12 bits copy sign.
// - Unpack count: unbiased, sign-removed exponent sign extended to 18 bits.
// - Pack copies low 48 bits and sign bit of coefficient source.
// - Pack exponent from low 11 index bits, biased, sign adjusted.
// - Add/subtract aligns smaller-exponent coefficient right by exponent difference.
// - Single sum adds into 96 bits, packs upper half, larger exponent.
// - Differences subtract second aligned coefficient from first.
// - Coefficient overflow shifts right one, exponent plus one.
// - Add/subtract results are never normalized.
// - Exponent difference above 128 makes aligned operand all sign bits.
// - Double forms deliver lower half of 96-bit result.
// - Double forms pack exponent as larger exponent minus 48.
// - Sign in bit 59, coefficient in low 48 bits.
`timescale 1ns/1ps
`default_nettype none

module fpau_core
(
   input  wire logic                          clk,
   input  wire logic                          sys_rst,
   input  wire logic                          issue_valid,
   input  wire logic [fpau_pkg::INSTR_W-1:0]  instr_word,
   input  wire logic [fpau_pkg::WORD_W-1:0]   first_operand_reg,
   input  wire logic [fpau_pkg::WORD_W-1:0]   second_operand_reg,
   input  wire logic [fpau_pkg::IDX_W-1:0]    index_count_reg,
   output var  fpau_pkg::fpau_wb_t            writeback
);
   import fpau_pkg::*;

   // ****************************************************************
   // Format helpers
   // ****************************************************************
   function automatic logic is_inf(input logic [WORD_W-1:0] w);
      return (w[59:48] == INF_POS_TOP) || (w[59:48] == INF_NEG_TOP);
   endfunction : is_inf

   function automatic logic is_indef(input logic [WORD_W-1:0] w);
      return (w[59:48] == IND_POS_TOP) || (w[59:48] == IND_NEG_TOP);
   endfunction : is_indef

   // Negative words hold the exponent field complemented
   function automatic logic signed [EXP_W-1:0] unbias(
      input logic [WORD_W-1:0] w);
      logic [EXP_W-1:0] f;
      f = w[59] ? ~w[58:48] : w[58:48];
      return {~f[10], f[9:0]};
   endfunction : unbias

   // Ones' complement exponents go through two's complement adders
   function automatic logic signed [11:0] oc_to_tc(
      input logic [EXP_W-1:0] e);
      return $signed({e[10], e}) + $signed({11'h000, e[10]});
   endfunction : oc_to_tc

   function automatic logic [EXP_W-1:0] tc_to_oc(input logic [11:0] x);
      return x[11] ? 11'(x - 12'h001) : x[10:0];
   endfunction : tc_to_oc

   function automatic logic [WORD_W-1:0] pack_word(
      input logic              s,
      input logic [EXP_W-1:0]  e,
      input logic [COEF_W-1:0] c);
      logic [EXP_W-1:0] f;
      f = {~e[10], e[9:0]};
      return {s, (s ? ~f : f), c};
   endfunction : pack_word

   // Ones' complement coefficient placed in the upper half of 96 bits,
   // shifted with sign fill, then converted to two's complement
   function automatic logic signed [98:0] align(
      input logic [WORD_W-1:0] w,
      input logic [11:0]       sh);
      logic signed [96:0] oc;
      logic        [96:0] t;
      oc = {w[59], w[47:0], {48{w[59]}}};
      if (sh > ALIGN_SAT)
      begin
         t = {97{w[59]}};
      end
      else
      begin
         t = oc >>> sh;
      end
      return $signed({{2{t[96]}}, t}) + $signed({98'h0, w[59]});
   endfunction : align

   function automatic logic [5:0] lead_count(
      input logic [48:0] x,
      input logic        s);
      logic [5:0] n;
      logic       run;
      n = '0;
      run = 1'b1;
      for (int i = 48; i >= 1; i--)
      begin
         if (run && (x[i] == s))
         begin
            n = n + 6'h01;
         end
         else
         begin
            run = 1'b0;
         end
      end
      return n;
   endfunction : lead_count

   // ****************************************************************
   // Decode
   // ****************************************************************
   fpau_instr_t ins;
   logic        is_addop;
   logic        is_sub;
   logic        is_dbl;

   assign ins      = fpau_instr_t'(instr_word);
   assign is_addop = (ins.opcode == OPC_FSUM) || (ins.opcode == OPC_FDIFF)
                  || (ins.opcode == OPC_DSUM) || (ins.opcode == OPC_DDIFF);
   assign is_sub   = (ins.opcode == OPC_FDIFF) || (ins.opcode == OPC_DDIFF);
   assign is_dbl   = (ins.opcode == OPC_DSUM) || (ins.opcode == OPC_DDIFF);

   // ****************************************************************
   // Add and subtract path
   // ****************************************************************
   logic signed [EXP_W-1:0] exp_j;
   logic signed [EXP_W-1:0] exp_k;
   logic signed [EXP_W-1:0] exp_big;
   logic signed [11:0]      exp_diff;
   logic        [11:0]      neg_diff;
   logic        [11:0]      shift_j;
   logic        [11:0]      shift_k;
   logic signed [98:0]      al_j;
   logic signed [98:0]      al_k;
   logic signed [98:0]      sum_s;
   logic signed [98:0]      neg_s;
   logic                    sum_neg;
   logic        [97:0]      mag;
   logic        [97:0]      mag_adj;
   logic                    coef_ovf;
   logic        [COEF_W-1:0] coef_sel;
   logic        [EXP_W-1:0] exp_res;
   logic        [WORD_W-1:0] add_word;

   assign exp_j    = unbias(first_operand_reg);
   assign exp_k    = unbias(second_operand_reg);
   assign exp_diff = oc_to_tc(exp_j) - oc_to_tc(exp_k);
   assign neg_diff = 12'(-exp_diff);
   assign shift_k  = exp_diff[11] ? 12'h000 : exp_diff;
   assign shift_j  = exp_diff[11] ? neg_diff : 12'h000;
   assign exp_big  = exp_diff[11] ? exp_k : exp_j;
   assign al_j     = align(first_operand_reg, shift_j);
   assign al_k     = align(second_operand_reg, shift_k);
   assign sum_s    = is_sub ? (al_j - al_k) : (al_j + al_k);
   assign neg_s    = -sum_s;
   assign sum_neg  = sum_s[98];
   assign mag      = sum_neg ? neg_s[97:0] : sum_s[97:0];
   assign coef_ovf = |mag[97:96];
   assign mag_adj  = coef_ovf ? (mag >> 1) : mag;
   // No leading-zero removal: the caller normalizes if needed
   assign coef_sel = is_dbl ? mag_adj[47:0] : mag_adj[95:48];
   assign exp_res  = tc_to_oc(oc_to_tc(exp_big) + 12'(coef_ovf)
                   - (is_dbl ? 12'(LOW_HALF_ADJ) : 12'h000));
   assign add_word = pack_word(sum_neg,
                               exp_res,
                               sum_neg ? ~coef_sel : coef_sel);

   // ****************************************************************
   // Round-normalize path
   // ****************************************************************
   logic [48:0]             rn_x;
   logic [5:0]              rn_n;
   logic [48:0]             rn_sh;
   logic [EXP_W-1:0]        rn_exp;
   logic                    rn_special;

   // Round bit is the complement of the sign, below the coefficient
   assign rn_x       = {second_operand_reg[47:0], ~second_operand_reg[59]};
   assign rn_n       = lead_count(rn_x, second_operand_reg[59]);
   assign rn_sh      = rn_x << rn_n;
   assign rn_exp     = tc_to_oc(oc_to_tc(exp_k) - 12'(rn_n));
   assign rn_special = is_inf(second_operand_reg)
                    || is_indef(second_operand_reg);

   // ****************************************************************
   // Writeback selection
   // ****************************************************************
   fpau_wb_t wb_nxt;
   fpau_wb_t wb_r;

   always_comb
   begin
      wb_nxt            = WB_RST;
      wb_nxt.result_sel = ins.result_sel;
      wb_nxt.index_sel  = ins.first_sel;
      if (issue_valid)
      begin
         unique case (1'b1)
            (ins.opcode == OPC_RND_NORM):
            begin
               wb_nxt.result_wr = 1'b1;
               wb_nxt.index_wr  = 1'b1;
               if (rn_special)
               begin
                  // Special operand passes through untouched
                  wb_nxt.result_word     = second_operand_reg;
                  wb_nxt.index_word      = '0;
                  wb_nxt.infinite_exit   = is_inf(second_operand_reg);
                  wb_nxt.indefinite_exit = is_indef(second_operand_reg);
               end
               else if (rn_n == ZERO_COEF_N)
               begin
                  wb_nxt.result_word = '0;
                  wb_nxt.index_word  = {12'h000, rn_n};
               end
               else
               begin
                  wb_nxt.result_word = pack_word(second_operand_reg[59],
                                                 rn_exp, rn_sh[48:1]);
                  wb_nxt.index_word  = {12'h000, rn_n};
               end
            end
            (ins.opcode == OPC_UNPACK):
            begin
               wb_nxt.result_wr   = 1'b1;
               wb_nxt.index_wr    = 1'b1;
               wb_nxt.result_word = {{12{second_operand_reg[59]}},
                                     second_operand_reg[47:0]};
               wb_nxt.index_word  = {{7{exp_k[10]}}, exp_k};
            end
            (ins.opcode == OPC_PACK):
            begin
               wb_nxt.result_wr   = 1'b1;
               wb_nxt.result_word = pack_word(second_operand_reg[59],
                                              index_count_reg[10:0],
                                              second_operand_reg[47:0]);
            end
            is_addop:
            begin
               wb_nxt.result_wr       = 1'b1;
               wb_nxt.result_word     = add_word;
               wb_nxt.infinite_exit   = is_inf(first_operand_reg)
                                     || is_inf(second_operand_reg);
               wb_nxt.indefinite_exit = is_indef(first_operand_reg)
                                     || is_indef(second_operand_reg);
            end
            default: wb_nxt.result_wr = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wb_r <= WB_RST;
      end
      else
      begin
         wb_r <= wb_nxt;
      end
   end

   assign writeback = wb_r;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic go_rn;
   logic go_unpack;
   logic go_pack;
   logic go_add;
   assign go_rn     = issue_valid && (ins.opcode == OPC_RND_NORM);
   assign go_unpack = issue_valid && (ins.opcode == OPC_UNPACK);
   assign go_pack   = issue_valid && (ins.opcode == OPC_PACK);
   assign go_add    = issue_valid && is_addop;
   a_rn_special_pass: assert property (
      go_rn && rn_special |=> writeback.result_wr
         && writeback.result_word == $past(second_operand_reg)
         && writeback.index_word == '0
         && (writeback.infinite_exit || writeback.indefinite_exit))
      else $error("special round-normalize operand not passed through");
   a_add_exit_flag: assert property (
      go_add && (is_inf(first_operand_reg) || is_inf(second_operand_reg))
      |=> writeback.infinite_exit)
      else $error("infinite operand did not raise exit");
   a_unpack_coef: assert property (
      go_unpack |=> writeback.result_word[47:0]
            == $past(second_operand_reg[47:0])
         && writeback.result_word[59:48] == {12{$past(second_operand_reg[59])}})
      else $error("unpack coefficient wrong");
   a_unpack_exp: assert property (
      go_unpack |=> writeback.index_wr
         && $signed(writeback.index_word)
            == $signed(unbias($past(second_operand_reg))))
      else $error("unpack exponent wrong");
   a_pack_coef: assert property (
      go_pack |=> writeback.result_word[47:0]
            == $past(second_operand_reg[47:0])
         && writeback.result_word[59] == $past(second_operand_reg[59])
         && !writeback.index_wr)
      else $error("pack coefficient or sign wrong");
   a_pack_round_trip: assert property (
      go_pack |=> unbias(writeback.result_word)
         == $signed($past(index_count_reg[10:0])))
      else $error("pack exponent does not unpack to index bits");
   a_diff_self_zero: assert property (
      issue_valid && ins.opcode == OPC_FDIFF
         && first_operand_reg == second_operand_reg
      |=> writeback.result_word[47:0] == 48'h0000_0000_0000)
      else $error("difference of equal operands not zero");
   a_big_shift_sum: assert property (
      issue_valid && ins.opcode == OPC_FSUM && !first_operand_reg[59]
         && !second_operand_reg[59] && !exp_diff[11]
         && exp_diff > 12'sh080
      |=> writeback.result_word[47:0] == $past(first_operand_reg[47:0]))
      else $error("far operand not reduced to sign copies");
   a_dbl_exp_adjust: assert property (
      issue_valid && ins.opcode == OPC_DSUM && !coef_ovf
         && first_operand_reg == second_operand_reg
         && first_operand_reg[59:48] == 12'h400
      |=> unbias(writeback.result_word) == ~LOW_HALF_ADJ)
      else $error("double sum exponent not reduced by 48");
   a_idle_no_write: assert property (
      !issue_valid |=> !writeback.result_wr && !writeback.index_wr
         && !writeback.infinite_exit && !writeback.indefinite_exit)
      else $error("write without issued instruction");
   c_rn_special: cover property (go_rn && rn_special);
   c_unpack:     cover property (go_unpack ##1 go_pack);
   c_add_ovf:    cover property (go_add && coef_ovf);
   c_dbl_diff:   cover property (go_add && is_dbl && is_sub);

endmodule : fpau_core
`default_nettype wire

// File: rtl/fpau_pkg.sv
// Package for the floating pack, unpack and add datapath
// ****************************************************************
// Widths, opcodes and exponent patterns
// ****************************************************************
package fpau_pkg;

   localparam int WORD_W  = 60;
   localparam int COEF_W  = 48;
   localparam int EXP_W   = 11;
   localparam int IDX_W   = 18;
   localparam int INSTR_W = 15;

   // Instruction field positions within the 15-bit word
   localparam int OPC_LSB = 9;
   localparam int RES_LSB = 6;
   localparam int FST_LSB = 3;
   localparam int SND_LSB = 0;

   localparam logic [5:0] OPC_RND_NORM = 6'h15;
   localparam logic [5:0] OPC_UNPACK   = 6'h16;
   localparam logic [5:0] OPC_PACK     = 6'h17;
   localparam logic [5:0] OPC_FSUM     = 6'h18;
   localparam logic [5:0] OPC_FDIFF    = 6'h19;
   localparam logic [5:0] OPC_DSUM     = 6'h1A;
   localparam logic [5:0] OPC_DDIFF    = 6'h1B;

   // Top 12 bits of special operands
   localparam logic [11:0] INF_POS_TOP = 12'h7FF;
   localparam logic [11:0] INF_NEG_TOP = 12'h800;
   localparam logic [11:0] IND_POS_TOP = 12'h3FF;
   localparam logic [11:0] IND_NEG_TOP = 12'hC00;

   localparam logic [11:0] ALIGN_SAT    = 12'h080;
   localparam logic [10:0] LOW_HALF_ADJ = 11'h030;
   localparam logic [5:0]  ZERO_COEF_N  = 6'h30;
   localparam int          LATENCY      = 1;

   typedef struct packed {
      logic [5:0] opcode;
      logic [2:0] result_sel;
      logic [2:0] first_sel;
      logic [2:0] second_sel;
   } fpau_instr_t;

   typedef struct packed {
      logic              result_wr;
      logic [2:0]        result_sel;
      logic [WORD_W-1:0] result_word;
      logic              index_wr;
      logic [2:0]        index_sel;
      logic [IDX_W-1:0]  index_word;
      logic              infinite_exit;
      logic              indefinite_exit;
   } fpau_wb_t;

   localparam fpau_wb_t WB_RST = '0;

endpackage : fpau_pkg

// File: verification/fpau_rf_model.sv
// Operand register file model on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none

module fpau_rf_model
(
   input  wire logic                          clk,
   input  wire logic [fpau_pkg::INSTR_W-1:0]  instr_word,
   input  wire fpau_pkg::fpau_wb_t            writeback,
   output logic [fpau_pkg::WORD_W-1:0]        first_operand_reg,
   output logic [fpau_pkg::WORD_W-1:0]        second_operand_reg,
   output logic [fpau_pkg::IDX_W-1:0]         index_count_reg
);
   import fpau_pkg::*;

   logic [WORD_W-1:0] xr [8];
   logic [IDX_W-1:0]  br [8];

   // ************************************************************
   // Operand read and write-back
   // ************************************************************
   always_comb
   begin
      first_operand_reg  = xr[instr_word[5:3]];
      second_operand_reg = xr[instr_word[2:0]];
      index_count_reg    = br[instr_word[5:3]];
   end

   // No bypass: a source read in the cycle of a write sees the old value
   always @(posedge clk)
   begin
      if (writeback.result_wr)
         xr[writeback.result_sel] <= writeback.result_word;
      if (writeback.index_wr)
         br[writeback.index_sel] <= writeback.index_word;
   end

endmodule : fpau_rf_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the floating pack, unpack and add datapath
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import fpau_pkg::*;

   localparam int WBW = $bits(fpau_wb_t);
   logic               clk = 1'b0;
   logic               sys_rst = 1'b1;
   logic               issue_valid = 1'b0;
   logic [INSTR_W-1:0] instr_word = '0;
   logic [WORD_W-1:0]  first_operand_reg;
   logic [WORD_W-1:0]  second_operand_reg;
   logic [IDX_W-1:0]   index_count_reg;
   fpau_wb_t           writeback;
   logic [WORD_W-1:0]  xm [8];
   logic [IDX_W-1:0]   bm [8];
   fpau_wb_t           exp_q [$];
   bit                 cw_q [$];
   logic               took = 1'b0;
   logic [31:0]        seed = 32'h1159_997b;
   logic [11:0]        tops [4];
   logic [5:0]         ops [7];
   int                 failures = 0;
   int                 cmp_count = 0;
   int                 cyc = 0;

   always #50 clk = ~clk;

   fpau_core uut (.clk(clk), .sys_rst(sys_rst), .issue_valid(issue_valid),
      .instr_word(instr_word), .first_operand_reg(first_operand_reg),
      .second_operand_reg(second_operand_reg),
      .index_count_reg(index_count_reg), .writeback(writeback));
   fpau_rf_model rf (.clk(clk), .instr_word(instr_word),
      .writeback(writeback), .first_operand_reg(first_operand_reg),
      .second_operand_reg(second_operand_reg),
      .index_count_reg(index_count_reg));

   // ************************************************************
   // Reference arithmetic, ones' complement words
   // ************************************************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [10:0] e11(int e);
      return (e < 0) ? ~11'(-e) : 11'(e);
   endfunction : e11

   // Built as a positive word, then complemented whole for a negative sign
   function automatic logic [59:0] mk(logic s, logic [10:0] e,
                                      logic [47:0] c);
      logic [59:0] w;
      w = {1'b0, e ^ 11'h400, c};
      return s ? ~w : w;
   endfunction : mk

   function automatic logic [10:0] xf(logic [59:0] w);
      return (w[59] ? ~w[58:48] : w[58:48]) ^ 11'h400;
   endfunction : xf

   function automatic int ue(logic [59:0] w);
      logic [10:0] f;
      logic [10:0] n;
      f = xf(w);
      n = ~f;
      return f[10] ? -int'(n) : int'(f);
   endfunction : ue

   function automatic logic [59:0] fadd(logic [59:0] a, b, logic sub, dbl);
      logic [98:0] va;
      logic [98:0] vb;
      logic [98:0] r;
      logic [98:0] m;
      int          e;
      e = (ue(a) > ue(b)) ? ue(a) : ue(b);
      va = {3'b0, a[59] ? ~a[47:0] : a[47:0], 48'b0} >> (e - ue(a));
      vb = {3'b0, b[59] ? ~b[47:0] : b[47:0], 48'b0} >> (e - ue(b));
      if (a[59])
         va = -va;
      if (b[59] ^ sub)
         vb = -vb;
      r = va + vb;
      m = r[98] ? -r : r;
      if (m[97:96] != 2'b00)
      begin
         m = m >> 1;
         e = e + 1;
      end
      if (dbl)
         return mk(r[98], e11(e - 48), m[47:0]);
      return mk(r[98], e11(e), m[95:48]);
   endfunction : fadd

   function automatic logic [1:0] spec(logic [59:0] w);
      return {w[59:48] == INF_POS_TOP || w[59:48] == INF_NEG_TOP,
              w[59:48] == IND_POS_TOP || w[59:48] == IND_NEG_TOP};
   endfunction : spec

   function automatic logic [59:0] rword();
      logic [47:0] c;
      logic [31:0] s;
      c = 48'({rnd(), rnd()});
      s = rnd();
      return mk(s[0], e11(int'(rnd() % 201) - 100), c);
   endfunction : rword

   // ************************************************************
   // Drivers and checking
   // ************************************************************
   task automatic load(int r, logic [59:0] x, logic [17:0] b);
      xm[r] = x;
      bm[r] = b;
      rf.xr[r] <= x;
      rf.br[r] <= b;
   endtask : load

   task automatic issue(logic [5:0] op, logic [2:0] i, j, k);
      fpau_wb_t    e;
      logic [59:0] xj;
      logic [59:0] xk;
      logic [10:0] f;
      bit          cw;
      e = '0;
      cw = 1'b1;
      xj = xm[j];
      xk = xm[k];
      @(posedge clk);
      issue_valid <= 1'b1;
      instr_word <= {op, i, j, k};
      e.result_wr = 1'b1;
      e.result_sel = i;
      e.index_sel = j;
      case (op)
         OPC_UNPACK:
         begin
            e.result_word = {{12{xk[59]}}, xk[47:0]};
            f = xf(xk);
            e.index_word = {{7{f[10]}}, f};
            e.index_wr = 1'b1;
         end
         OPC_PACK:
            e.result_word = mk(xk[59], bm[j][10:0],
                               xk[59] ? ~xk[47:0] : xk[47:0]);
         OPC_RND_NORM:
         begin
            e.result_word = xk;
            e.index_wr = 1'b1;
            {e.infinite_exit, e.indefinite_exit} = spec(xk);
         end
         OPC_FSUM, OPC_FDIFF, OPC_DSUM, OPC_DDIFF:
         begin
            e.result_word = fadd(xj, xk, op[0], op[1]);
            {e.infinite_exit, e.indefinite_exit} = spec(xj) | spec(xk);
            // Word of a special operand is left to exit handling
            cw = (spec(xj) | spec(xk)) == 2'b00;
         end
         default:
            e.result_wr = 1'b0;
      endcase
      if (e.result_wr)
         xm[i] = e.result_word;
      if (e.index_wr)
         bm[j] = e.index_word;
      exp_q.push_back(e);
      cw_q.push_back(cw);
   endtask : issue

   task automatic idle(int n);
      repeat (n)
      begin
         @(posedge clk);
         issue_valid <= 1'b0;
      end
   endtask : idle

   task automatic check(string nm, logic [WBW-1:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic done(string t);
      $display("test %s ended, %0d checks", t, cmp_count);
   endtask : done

   task automatic print_verdict();
      $display("checks %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict

   always @(posedge clk)
   begin
      took <= issue_valid & ~sys_rst;
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         failures++;
         print_verdict();
      end
   end

   // Every cycle is checked; idle and refused cycles must show no strobe
   always @(negedge clk)
   begin : mon
      fpau_wb_t e;
      fpau_wb_t m;
      bit       cw;
      e = '0;
      m = '1;
      cw = 1'b1;
      if (took)
      begin
         e = exp_q.pop_front();
         cw = cw_q.pop_front();
      end
      if (!sys_rst)
      begin
         if (!e.result_wr || !cw)
            m.result_word = '0;
         if (!e.result_wr)
            m.result_sel = '0;
         if (!e.index_wr)
            m.index_sel = '0;
         if (!e.index_wr)
            m.index_word = '0;
      end
      if (cyc > 0)
         check("writeback", writeback & m, e & m);
   end

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial
   begin
      tops = '{INF_POS_TOP, INF_NEG_TOP, IND_POS_TOP, IND_NEG_TOP};
      ops = '{OPC_UNPACK, OPC_PACK, OPC_FSUM, OPC_FDIFF, OPC_DSUM,
              OPC_DDIFF, 6'h1C};
      for (int r = 0; r < 8; r++)
         load(r, '0, '0);
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      done("reset");
      load(0, mk(1'b0, e11(10), 48'hFFFF_FFFF_FFFF), 18'h0_0000);
      load(1, mk(1'b0, e11(140), 48'h8000_0000_0001), 18'h3_F81C);
      load(2, mk(1'b1, e11(10), 48'h8000_0000_0000), 18'h0_0401);
      load(3, mk(1'b0, e11(140), 48'h8000_0000_0000), 18'h2_07FF);
      // Back to back; results kept clear of the sources
      issue(OPC_FSUM, 3'd4, 3'd0, 3'd0);
      issue(OPC_FDIFF, 3'd5, 3'd1, 3'd3);
      issue(OPC_FSUM, 3'd6, 3'd1, 3'd2);
      issue(OPC_FSUM, 3'd6, 3'd1, 3'd0);
      issue(OPC_FDIFF, 3'd7, 3'd3, 3'd3);
      issue(OPC_DSUM, 3'd7, 3'd0, 3'd1);
      issue(OPC_DDIFF, 3'd4, 3'd2, 3'd0);
      issue(OPC_UNPACK, 3'd5, 3'd3, 3'd2);
      issue(OPC_PACK, 3'd6, 3'd1, 3'd2);
      issue(6'h14, 3'd7, 3'd0, 3'd0);
      idle(3);
      load(0, mk(1'b0, e11(0), 48'h0123_4567_89AB), 18'h0_0000);
      issue(OPC_DSUM, 3'd7, 3'd0, 3'd0);
      idle(3);
      done("directed");
      for (int n = 0; n < 4; n++)
      begin
         load(2, {tops[n], 48'h0123_4567_89AB}, 18'h0_0000);
         issue(OPC_RND_NORM, 3'd4, 3'd5, 3'd2);
         issue(OPC_FSUM + 6'(n), 3'd6, n[0] ? 3'd2 : 3'd1,
               n[0] ? 3'd1 : 3'd2);
         idle(3);
      end
      done("special");
      for (int n = 0; n < 150; n++)
      begin
         for (int r = 0; r < 8; r++)
            load(r, rword(), 18'(rnd()));
         issue(ops[rnd() % 7], 3'(rnd()), 3'(rnd()), 3'(rnd()));
         idle(3);
      end
      done("random");
      print_verdict();
   end

endmodule : testbench
`default_nettype wire
